//--- tb/rciu_seq_model.sv
// partner: instruction sequencer giving one-cycle instruction pulses and
// acknowledging a vector request ack_wait+1 cycles after it rises.
// assumes the bench calls issue() and sets ack_wait between vectors.
`timescale 1ns/100ps
module rciu_seq_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic vector_req,
  input wire logic [3:0] ack_wait,
  output logic watchdog_clear_instr,
  output logic sleep_instr,
  output logic global_irq_enable_instr,
  output logic global_irq_disable_instr,
  output logic return_from_irq_instr,
  output logic sw_irq_instr,
  output logic vector_ack
);
  logic [5:0] instr_q = 6'h00;
  logic [3:0] cnt_q;

  assign {sw_irq_instr, return_from_irq_instr, global_irq_disable_instr,
    global_irq_enable_instr, sleep_instr, watchdog_clear_instr} = instr_q;

  task automatic issue(input int n);
    @(posedge pclk);
    instr_q[n] <= 1'b1;
    @(posedge pclk);
    instr_q[n] <= 1'b0;
  endtask : issue

  // ack lasts one cycle so the cleared request is never acked twice
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vector_ack <= 1'b0;
      cnt_q <= 4'h0;
    end else if (vector_ack) begin
      vector_ack <= 1'b0;
      cnt_q <= 4'h0;
    end else if (vector_req) begin
      vector_ack <= (cnt_q == ack_wait);
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule : rciu_seq_model

//--- tb/rciu_top_asserts.sv
// checker: port-level properties of the reset-cause and interrupt unit.
// assumes it is bound to rciu_top; pins pass a two-flop synchroniser.
`timescale 1ns/100ps
module rciu_top_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  input wire logic reset_pin_n,
  input wire logic watchdog_expired,
  input wire logic sleep_instr,
  input wire logic global_irq_enable_instr,
  input wire logic return_from_irq_instr,
  input wire logic sw_irq_instr,
  input wire logic vector_ack,
  input wire logic core_reset,
  input wire logic core_sleeping,
  input wire logic [2:0] irq_request,
  input wire logic vector_req,
  input wire logic [9:0] vector_addr
);
  // ----
  // properties
  // ----
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence mask_clear_write;
    psel && penable && pwrite && paddr == rciu_pkg::RCIU_MASK_OFF &&
      pwdata[2:0] == 3'h0;
  endsequence

  // ack, then a cycle with no enable: a still-set gie would re-vector here
  sequence ack_then_quiet;
    (vector_ack && !global_irq_enable_instr && !return_from_irq_instr) ##1
      (!global_irq_enable_instr && !return_from_irq_instr);
  endsequence

  sequence sw_taken;
    $rose(vector_req) && ($past(sw_irq_instr) || $past(sw_irq_instr, 2));
  endsequence

  AST_RESET_PIN: assert property (
    $fell(reset_pin_n) |-> ##[1:3] core_reset)
    else $error("reset pin fall gave no core reset");
  AST_WATCHDOG: assert property (
    $rose(watchdog_expired) |-> ##[1:3] core_reset)
    else $error("watchdog expiry gave no core reset");
  AST_SW_VECTOR: assert property (
    sw_taken |-> vector_addr == rciu_pkg::RCIU_SW_VECTOR)
    else $error("software vector address wrong");
  AST_HW_VECTOR: assert property (
    $rose(vector_req) && !$past(sw_irq_instr) && !$past(sw_irq_instr, 2)
      |-> vector_addr == rciu_pkg::RCIU_HW_VECTOR)
    else $error("hardware vector address wrong");
  AST_REQ_HOLD: assert property (
    vector_req && !vector_ack |=> vector_req)
    else $error("vector request dropped before ack");
  AST_ACK_BLOCKS: assert property (
    ack_then_quiet |=> !vector_req)
    else $error("vector taken again with global enable cleared");
  AST_NO_WAKE_VECTOR: assert property (
    core_sleeping |=> !$rose(vector_req))
    else $error("vectored while asleep");
  AST_SLEEP_ENTRY: assert property (
    sleep_instr && !core_sleeping && !watchdog_expired && reset_pin_n
      |=> core_sleeping)
    else $error("sleep instruction did not enter sleep");
  AST_MASK_ZERO: assert property (
    mask_clear_write |=> irq_request == 3'h0)
    else $error("request seen with all mask bits clear");
  AST_UNMAPPED: assert property (
    psel && penable && paddr > rciu_pkg::RCIU_INSTR_OFF |-> pslverr)
    else $error("unmapped access not refused");
endmodule : rciu_top_asserts

//--- tb/test_reset_cause_and_interrupt_unit.sv
// bench: apb, pins and sequencer model against rciu_top.
// assumes zero-wait apb answers and a 50 mhz pclk.
`timescale 1ns/100ps
module test_reset_cause_and_interrupt_unit;
  localparam logic [7:0] ST = rciu_pkg::RCIU_STATUS_OFF;
  localparam logic [7:0] FL = rciu_pkg::RCIU_FLAG_OFF;
  localparam logic [7:0] MK = rciu_pkg::RCIU_MASK_OFF;
  localparam logic [7:0] PT = rciu_pkg::RCIU_PORT_OFF;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, reset_pin_n = 1'b1;
  logic watchdog_expired = 1'b0, timer_counter_ovf_n = 1'b1, vector_ack;
  logic watchdog_clear_instr, sleep_instr, global_irq_enable_instr;
  logic global_irq_disable_instr, return_from_irq_instr, sw_irq_instr;
  logic core_reset, core_sleeping, vector_req;
  logic [7:0] paddr = 8'h00, port_pins = 8'hff;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [2:0] irq_request;
  logic [9:0] vector_addr;
  logic [3:0] ack_wait = 4'h0;
  int mismatches = 0, samples_checked = 0, cycles = 0;

  rciu_top uut (.*);
  rciu_seq_model seq (.*);

  always #10 pclk = ~pclk;

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  // ----
  // tasks
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    check({31'h0, pslverr}, {31'h0, a > rciu_pkg::RCIU_INSTR_OFF});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rd_chk

  task automatic settle();
    repeat (5) @(posedge pclk);
  endtask : settle

  task automatic rst_pin();
    @(posedge pclk);
    reset_pin_n <= 1'b0;
    settle();
    reset_pin_n <= 1'b1;
    settle();
  endtask : rst_pin

  task automatic wdog();
    @(posedge pclk);
    watchdog_expired <= 1'b1;
    @(posedge pclk);
    watchdog_expired <= 1'b0;
    settle();
  endtask : wdog

  task automatic expect_vector(input logic [9:0] addr);
    for (int i = 0; i < 20 && vector_req !== 1'b1; i++)
      @(posedge pclk);
    check({22'h0, vector_addr}, {22'h0, addr});
    repeat (ack_wait + 4) @(posedge pclk);
    check({31'h0, vector_req}, 32'h0);
  endtask : expect_vector

  task automatic tally_and_finish();
    if (mismatches == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  // ----
  // sequence
  // ----
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    check({31'h0, core_reset}, 32'h0);
    rd_chk(ST, 32'h03);
    rd_chk(FL, 32'h0);
    rd_chk(MK, 32'h0);
    rd_chk(8'h14, 32'hff);
    rd_chk(8'h1c, 32'h0);
    wdog();
    rd_chk(ST, 32'h01);
    apb(1'b1, rciu_pkg::RCIU_INSTR_OFF, 32'h1);
    rd_chk(ST, 32'h03);
    seq.issue(rciu_pkg::RCIU_I_SLP);
    rd_chk(ST, 32'h12);
    wdog();
    rd_chk(ST, 32'h00);
    seq.issue(rciu_pkg::RCIU_I_SLP);
    rst_pin();
    rd_chk(ST, 32'h02);
    rd_chk(PT, 32'hff);
    apb(1'b1, MK, 32'h2);
    seq.issue(rciu_pkg::RCIU_I_SLP);
    port_pins <= 8'hf7;
    settle();
    rd_chk(ST, 32'h06);
    check({31'h0, vector_req}, 32'h0);
    rd_chk(FL, 32'h2);
    check({29'h0, irq_request}, 32'h2);
    rd_chk(PT, 32'hf7);
    apb(1'b1, FL, 32'h0);
    rst_pin();
    rd_chk(ST, 32'h02);
    apb(1'b1, MK, 32'h0);
    seq.issue(rciu_pkg::RCIU_I_SLP);
    port_pins <= 8'hff;
    settle();
    apb(1'b1, MK, 32'h2);
    settle();
    check({31'h0, core_sleeping}, 32'h1);
    rst_pin();
    apb(1'b1, 8'h14, 32'hf7);
    apb(1'b1, 8'h0c, 32'h1);
    rd_chk(PT, 32'hff);
    apb(1'b1, FL, 32'h0);
    port_pins <= 8'hf7;
    settle();
    rd_chk(FL, 32'h0);
    port_pins <= 8'hf6;
    settle();
    rd_chk(FL, 32'h4);
    timer_counter_ovf_n <= 1'b0;
    settle();
    timer_counter_ovf_n <= 1'b1;
    rd_chk(FL, 32'h5);
    check({29'h0, irq_request}, 32'h0);
    apb(1'b1, FL, 32'h1);
    apb(1'b1, MK, 32'h1);
    @(posedge pclk);
    check({29'h0, irq_request}, 32'h1);
    seq.issue(rciu_pkg::RCIU_I_ENI);
    expect_vector(rciu_pkg::RCIU_HW_VECTOR);
    rd_chk(ST, 32'h02);
    apb(1'b1, FL, 32'h0);
    seq.issue(rciu_pkg::RCIU_I_RET);
    rd_chk(ST, 32'h0a);
    seq.issue(rciu_pkg::RCIU_I_DIS);
    rd_chk(ST, 32'h02);
    seq.issue(rciu_pkg::RCIU_I_ENI);
    ack_wait <= 4'h5;
    seq.issue(rciu_pkg::RCIU_I_SWI);
    expect_vector(rciu_pkg::RCIU_SW_VECTOR);
    rd_chk(ST, 32'h02);
    tally_and_finish();
  end
endmodule : test_reset_cause_and_interrupt_unit

bind rciu_top rciu_top_asserts chk (.*);

//--- verilog/rciu_edge.sv
// falling-edge detector on an already synchronised level.
// assumes input is in the pclk domain and resets low like the synchroniser,
// so a pin idling high shows no false fall after reset.
`timescale 1ns/100ps
module rciu_edge (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic level,
  output logic fall
);

  logic last_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // matches the synchroniser's reset output: a high reset here would
      // turn its first cycles of zero into a spurious edge
      last_q <= 1'b0;
    end else begin
      last_q <= level;
    end
  end

  assign fall = last_q & ~level;

endmodule : rciu_edge

//--- verilog/rciu_pkg.sv
// package: register map, field positions, reset values and vectors for the
// reset-cause and interrupt unit.
// assumes a 32-bit apb slave on pclk, one aligned word per register.
package rciu_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] RCIU_STATUS_OFF = 8'h00;
  localparam logic [7:0] RCIU_FLAG_OFF = 8'h04;
  localparam logic [7:0] RCIU_MASK_OFF = 8'h08;
  localparam logic [7:0] RCIU_CTRL_OFF = 8'h0c;
  localparam logic [7:0] RCIU_PORT_OFF = 8'h10;
  localparam logic [7:0] RCIU_DIR_OFF = 8'h14;
  localparam logic [7:0] RCIU_INSTR_OFF = 8'h18;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  // cause register: bit 0 power-down, bit 1 timeout, bit 2 pin-change wake
  localparam int RCIU_PD_BIT = 0;
  localparam int RCIU_TO_BIT = 1;
  localparam int RCIU_WK_BIT = 2;
  localparam int RCIU_GIE_BIT = 3;
  localparam int RCIU_SLEEP_BIT = 4;
  // flag and mask registers: timer, input change, external
  localparam int RCIU_TMR_BIT = 0;
  localparam int RCIU_ICH_BIT = 1;
  localparam int RCIU_EXT_BIT = 2;
  // control register: bit 0 selects shared pin as external irq input
  localparam int RCIU_EXTSEL_BIT = 0;
  // software instruction register bits (write one to execute)
  localparam int RCIU_I_WDC = 0;
  localparam int RCIU_I_SLP = 1;
  localparam int RCIU_I_ENI = 2;
  localparam int RCIU_I_DIS = 3;
  localparam int RCIU_I_RET = 4;
  localparam int RCIU_I_SWI = 5;

  // ----------------------------------------------------------------
  // widths, reset values, vectors
  // ----------------------------------------------------------------
  localparam int RCIU_PORT_W = 8;
  localparam int RCIU_PC_W = 10;
  localparam logic [2:0] RCIU_CAUSE_POR = 3'h3;
  localparam logic [2:0] RCIU_MASK_RST = 3'h0;
  localparam logic [7:0] RCIU_DIR_RST = 8'hff;
  localparam logic [9:0] RCIU_HW_VECTOR = 10'h008;
  localparam logic [9:0] RCIU_SW_VECTOR = 10'h001;

  typedef enum logic [1:0] {
    RCIU_RUN,
    RCIU_SLEEP
  } rciu_mode_type;

endpackage : rciu_pkg

//--- verilog/rciu_sync.sv
// two-flop synchroniser for a bus of asynchronous pin levels.
// assumes the levels are slow compared with pclk.
`timescale 1ns/100ps
module rciu_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : rciu_sync

//--- verilog/rciu_top.sv
// top of the reset-cause and interrupt unit: cause bits, flags, mask,
// global enable, sleep state, vector request and the apb slave.
// assumes presetn from an outside power-on detector; pins are async.
`timescale 1ns/100ps

// Function
// - reset core on power-on, reset pin pulse, or watchdog expiry (core_reset stays low at power-on; only pin and watchdog drive it)
// - power-on sets wake 0, timeout 1, power-down 1
// - reset pin while running clears wake, keeps timeout and power-down
// - reset pin from sleep gives wake 0, timeout 1, power-down 0
// - watchdog while running clears wake and timeout, keeps power-down
// - watchdog from sleep clears wake, timeout and power-down
// - pin-change wake gives wake 1, timeout 1, power-down 0
// - watchdog-clear sets timeout and power-down; sleep sets timeout, clears power-down
// - three sources: timer and external pin on falling edges, input change on any change
// - port pins raise change events unless output or external irq pin
// - input change wakes from sleep only if enabled before sleeping
// - after pin-change wake, continue in line or vector if enabled
// - flags recorded in a flag register, separate mask register
// - enable instruction sets global enable, disable clears it
// - enabled interrupt fetches next instruction from 008h
// - flags other than input change set regardless of mask or enable
// - request to the core is flags ANDed with mask bits
// - return instruction ends the routine and sets global enable
// - enabled software interrupt fetches next instruction from 001h
module rciu_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reset_pin_n,
  input wire logic watchdog_expired,
  input wire logic timer_counter_ovf_n,
  input wire logic [7:0] port_pins,
  input wire logic watchdog_clear_instr,
  input wire logic sleep_instr,
  input wire logic global_irq_enable_instr,
  input wire logic global_irq_disable_instr,
  input wire logic return_from_irq_instr,
  input wire logic sw_irq_instr,
  input wire logic vector_ack,
  output logic core_reset,
  output logic core_sleeping,
  output logic [2:0] irq_request,
  output logic vector_req,
  output logic [9:0] vector_addr
);

  // ----------------------------------------------------------------
  // pin synchronisers and edges
  // ----------------------------------------------------------------
  logic [7:0] port_s;
  logic rst_pin_s;
  logic tmr_s;
  logic wdt_s;
  logic tmr_fall;
  logic ext_fall;
  logic rst_fall;

  rciu_sync #(.W(11)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({port_pins, reset_pin_n, timer_counter_ovf_n,
               watchdog_expired}),
    .sync_out({port_s, rst_pin_s, tmr_s, wdt_s})
  );

  rciu_edge u_tmr_edge (
    .pclk(pclk),
    .presetn(presetn),
    .level(tmr_s),
    .fall(tmr_fall)
  );

  rciu_edge u_ext_edge (
    .pclk(pclk),
    .presetn(presetn),
    .level(port_s[0]),
    .fall(ext_fall)
  );

  rciu_edge u_rst_edge (
    .pclk(pclk),
    .presetn(presetn),
    .level(rst_pin_s),
    .fall(rst_fall)
  );

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [2:0] flag_q;
  logic [2:0] mask_q;
  logic ext_sel_q;
  logic [7:0] dir_q;
  logic [7:0] ref_q;
  logic [2:0] cause_q;
  logic gie_q;
  logic ich_armed_q;
  logic [5:0] sw_instr;
  rciu_pkg::rciu_mode_type mode_q;

  always_comb begin
    case (paddr)
      rciu_pkg::RCIU_STATUS_OFF, rciu_pkg::RCIU_FLAG_OFF,
      rciu_pkg::RCIU_MASK_OFF, rciu_pkg::RCIU_CTRL_OFF,
      rciu_pkg::RCIU_PORT_OFF, rciu_pkg::RCIU_DIR_OFF,
      rciu_pkg::RCIU_INSTR_OFF: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign wr_en = psel & penable & pwrite & addr_ok;
  assign rd_en = psel & penable & ~pwrite & addr_ok;

  // instructions arrive from the sequencer or from the instruction register
  assign sw_instr = (wr_en && paddr == rciu_pkg::RCIU_INSTR_OFF) ?
                    pwdata[5:0] : 6'h00;

  logic i_wdc;
  logic i_slp;
  logic i_eni;
  logic i_dis;
  logic i_ret;
  logic i_swi;
  assign i_wdc = watchdog_clear_instr | sw_instr[rciu_pkg::RCIU_I_WDC];
  assign i_slp = sleep_instr | sw_instr[rciu_pkg::RCIU_I_SLP];
  assign i_eni = global_irq_enable_instr | sw_instr[rciu_pkg::RCIU_I_ENI];
  assign i_dis = global_irq_disable_instr | sw_instr[rciu_pkg::RCIU_I_DIS];
  assign i_ret = return_from_irq_instr | sw_instr[rciu_pkg::RCIU_I_RET];
  assign i_swi = sw_irq_instr | sw_instr[rciu_pkg::RCIU_I_SWI];

  // ----------------------------------------------------------------
  // input-change detection
  // ----------------------------------------------------------------
  logic [7:0] watch;
  logic ich_event;
  logic port_read;

  // outputs and the external irq pin never count as changes
  always_comb begin
    watch = dir_q;
    watch[0] = dir_q[0] & ~ext_sel_q;
  end
  assign ich_event = |((port_s ^ ref_q) & watch);
  // the reference only follows a port read, so software must read first
  assign port_read = rd_en && paddr == rciu_pkg::RCIU_PORT_OFF;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_q <= 8'h00;
    end else if (port_read) begin
      ref_q <= port_s;
    end
  end

  // ----------------------------------------------------------------
  // reset and wake events
  // ----------------------------------------------------------------
  logic asleep;
  logic wake_pin;
  logic wdt_ev;
  assign asleep = mode_q == rciu_pkg::RCIU_SLEEP;
  assign wdt_ev = wdt_s;
  // only an interrupt armed before sleep may wake on a change
  assign wake_pin = asleep & ich_event & ich_armed_q;

  assign core_reset = rst_fall | wdt_ev;
  assign core_sleeping = asleep;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= rciu_pkg::RCIU_RUN;
    end else begin
      case (mode_q)
        rciu_pkg::RCIU_RUN: begin
          if (i_slp) begin
            mode_q <= rciu_pkg::RCIU_SLEEP;
          end
        end
        rciu_pkg::RCIU_SLEEP: begin
          if (rst_fall || wdt_ev || wake_pin) begin
            mode_q <= rciu_pkg::RCIU_RUN;
          end
        end
        default: mode_q <= rciu_pkg::RCIU_RUN;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ich_armed_q <= 1'b0;
    end else if (i_slp && !asleep) begin
      ich_armed_q <= mask_q[rciu_pkg::RCIU_ICH_BIT];
    end
  end

  // ----------------------------------------------------------------
  // cause bits {wake, timeout, power-down}
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_q <= rciu_pkg::RCIU_CAUSE_POR;
    end else if (wdt_ev && asleep) begin
      cause_q <= 3'h0;
    end else if (wdt_ev) begin
      cause_q <= {1'b0, 1'b0, cause_q[rciu_pkg::RCIU_PD_BIT]};
    end else if (rst_fall && asleep) begin
      cause_q <= 3'h2;
    end else if (rst_fall) begin
      cause_q <= {1'b0, cause_q[1:0]};
    end else if (wake_pin) begin
      cause_q <= 3'h6;
    end else if (i_wdc) begin
      cause_q <= {cause_q[rciu_pkg::RCIU_WK_BIT], 2'h3};
    end else if (i_slp && !asleep) begin
      cause_q <= {cause_q[rciu_pkg::RCIU_WK_BIT], 2'h2};
    end
  end

  // ----------------------------------------------------------------
  // flags, mask, control
  // ----------------------------------------------------------------
  logic [2:0] flag_set;
  logic [2:0] flag_clr;
  assign flag_set[rciu_pkg::RCIU_TMR_BIT] = tmr_fall;
  assign flag_set[rciu_pkg::RCIU_EXT_BIT] = ext_fall & ext_sel_q;
  // the change flag is gated by its own enable, unlike the others
  assign flag_set[rciu_pkg::RCIU_ICH_BIT] =
    ich_event & mask_q[rciu_pkg::RCIU_ICH_BIT];
  assign flag_clr = (wr_en && paddr == rciu_pkg::RCIU_FLAG_OFF) ?
                    ~pwdata[2:0] : 3'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 3'h0;
    end else begin
      // set wins over a same-cycle clear; write zero to clear a flag
      flag_q <= (flag_q & ~flag_clr) | flag_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= rciu_pkg::RCIU_MASK_RST;
    end else if (wr_en && paddr == rciu_pkg::RCIU_MASK_OFF) begin
      mask_q <= pwdata[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_sel_q <= 1'b0;
      dir_q <= rciu_pkg::RCIU_DIR_RST;
    end else if (wr_en && paddr == rciu_pkg::RCIU_CTRL_OFF) begin
      ext_sel_q <= pwdata[rciu_pkg::RCIU_EXTSEL_BIT];
    end else if (wr_en && paddr == rciu_pkg::RCIU_DIR_OFF) begin
      dir_q <= pwdata[7:0];
    end
  end

  assign irq_request = flag_q & mask_q;

  // ----------------------------------------------------------------
  // global enable and vectoring
  // ----------------------------------------------------------------
  logic take_hw;
  logic take_sw;
  logic vec_pend_q;
  logic [9:0] vec_q;

  // no vectoring while asleep: a wake with enable off resumes in line
  assign take_hw = gie_q & (|irq_request) & ~asleep & ~vec_pend_q;
  assign take_sw = gie_q & i_swi & ~asleep & ~vec_pend_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gie_q <= 1'b0;
    end else if (take_hw || take_sw) begin
      gie_q <= 1'b0;
    end else if (i_dis) begin
      gie_q <= 1'b0;
    end else if (i_eni || i_ret) begin
      gie_q <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec_pend_q <= 1'b0;
      vec_q <= 10'h000;
    end else if (take_sw) begin
      vec_pend_q <= 1'b1;
      vec_q <= rciu_pkg::RCIU_SW_VECTOR;
    end else if (take_hw) begin
      vec_pend_q <= 1'b1;
      vec_q <= rciu_pkg::RCIU_HW_VECTOR;
    end else if (vector_ack) begin
      vec_pend_q <= 1'b0;
    end
  end

  assign vector_req = vec_pend_q;
  assign vector_addr = vec_q;

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        rciu_pkg::RCIU_STATUS_OFF:
          prdata <= {27'h0, asleep, gie_q, cause_q};
        rciu_pkg::RCIU_FLAG_OFF: prdata <= {29'h0, flag_q};
        rciu_pkg::RCIU_MASK_OFF: prdata <= {29'h0, mask_q};
        rciu_pkg::RCIU_CTRL_OFF: prdata <= {31'h0, ext_sel_q};
        rciu_pkg::RCIU_PORT_OFF: prdata <= {24'h0, port_s};
        rciu_pkg::RCIU_DIR_OFF: prdata <= {24'h0, dir_q};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule : rciu_top
